// >>> logic/ciefc_ctrl.sv
// Overview of operation
// - Each source flag sets on its event regardless of its enable or global enable.
// - Global enable bit 7 set lets unmasked sources request; clear blocks all.
// - Peripheral gate bit 6 must be set for any peripheral request.
// - Control bit 5 enables the timer0 overflow request.
// - Control bit 4 enables the external edge pin request.
// - Control bit 3 enables port-change; each pin also needs its mask bit.
// - Timer0 rollover sets flag bit 2; it holds until software writes 0.
// - Reset leaves timer0 count unchanged; software loads it before clearing the flag.
// - External edge event sets bit 1; it holds until software clears it.
// - A change on any port pin 5 to 0 whose mask bit is set sets bit 0 until cleared.
// - Peripheral enable bit 6 gates the converter done request.
// - Peripheral enable bit 5 gates the capture/compare request.
// - Peripheral enable bits 4 and 3 gate comparator two and one.
// - Peripheral enable bit 1 gates the timer2 period match request.
// - Peripheral enable bit 0 gates the timer1 overflow request.
// - Reduced variant: converter, capture/compare and timer2 enables read zero.
// - Peripheral flags arrive as an input word of event flags.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module ciefc_ctrl #(
  parameter bit FULL_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Event sources
  input wire logic timer0_tick,
  input wire logic ext_edge_pin,
  input wire logic ext_edge_rising,
  input wire logic [5:0] port_a_pins,
  input wire logic [5:0] port_change_mask,
  input wire logic [7:0] peripheral_flag_word,
  // Request to the core
  output logic core_irq_req
);

  // ****************************************
  // Register bus
  // ****************************************
  ciefc_pkg::ciefc_req_t req;
  ciefc_pkg::ciefc_rsp_t rsp;
  logic wr_en;

  ciefc_apb_port u_apb (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .req(req),
    .wr_en(wr_en),
    .rsp(rsp)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic [5:0] port_level;
  logic [5:0] port_rise;
  logic [5:0] port_fall;

  ciefc_pin_sync #(.W(1)) u_ext_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pins(ext_edge_pin),
    .level(ext_level),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  ciefc_pin_sync #(.W(ciefc_pkg::PORT_W)) u_port_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pins(port_a_pins),
    .level(port_level),
    .rise(port_rise),
    .fall(port_fall)
  );

  // ****************************************
  // Address decode
  // ****************************************
  logic sel_ctrl;
  logic sel_pie;
  logic sel_t0;
  logic sel_stat;
  logic wr_ctrl;
  logic wr_pie;
  logic wr_t0;

  always_comb begin
    sel_ctrl = 1'b0;
    sel_pie = 1'b0;
    sel_t0 = 1'b0;
    sel_stat = 1'b0;
    if (req.addr == ciefc_pkg::CTRL_OFF) begin
      sel_ctrl = 1'b1;
    end else if (req.addr == ciefc_pkg::PIE_OFF) begin
      sel_pie = 1'b1;
    end else if (req.addr == ciefc_pkg::T0CNT_OFF) begin
      sel_t0 = 1'b1;
    end else if (req.addr == ciefc_pkg::STAT_OFF) begin
      sel_stat = 1'b1;
    end
  end

  // Status is read-only, so a write to it is simply dropped
  assign wr_ctrl = wr_en & sel_ctrl;
  assign wr_pie = wr_en & sel_pie;
  assign wr_t0 = wr_en & sel_t0;

  // ****************************************
  // Timer0 count
  // ****************************************
  logic [7:0] t0cnt_q;
  logic t0_ovf;

  assign t0_ovf = timer0_tick & ~wr_t0 & ~rst & (t0cnt_q == ciefc_pkg::T0_MAX);

  // No reset branch: the count survives reset, software must load it
  always_ff @(posedge core_clk) begin
    if (!rst) begin
      if (wr_t0) begin
        t0cnt_q <= req.wdata[7:0];
      end else if (timer0_tick) begin
        t0cnt_q <= t0cnt_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Core control register
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic ext_evt;
  logic port_evt;
  logic [ciefc_pkg::NUM_CORE_SRC-1:0] core_evt;

  assign ext_evt = ext_edge_rising ? ext_rise : ext_fall;
  assign port_evt = |((port_rise | port_fall) & port_change_mask);
  assign core_evt[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT] = t0_ovf;
  assign core_evt[ciefc_pkg::EXTF_BIT] = ext_evt;
  assign core_evt[ciefc_pkg::PCF_BIT] = port_evt;

  assign ctrl_d[7:ciefc_pkg::NUM_CORE_SRC] = wr_ctrl ? req.wdata[7:ciefc_pkg::NUM_CORE_SRC]
                                                     : ctrl_q[7:ciefc_pkg::NUM_CORE_SRC];

  // Flags set from events or a write of 1, not from enables; an event in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < ciefc_pkg::NUM_CORE_SRC; gi++) begin : g_flag
      assign ctrl_d[gi] = core_evt[gi] | (wr_ctrl ? req.wdata[gi] : ctrl_q[gi]);
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= ciefc_pkg::CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************
  // Peripheral enable register
  // ****************************************
  logic [7:0] pie_q;
  logic [7:0] pie_impl;

  // Reduced parts lack the converter, capture/compare and timer2
  assign pie_impl = FULL_VARIANT ? ciefc_pkg::PIE_IMPL_FULL : ciefc_pkg::PIE_IMPL_RED;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pie_q <= ciefc_pkg::PIE_RST;
    end else if (wr_pie) begin
      pie_q <= req.wdata[7:0] & pie_impl;
    end
  end

  // ****************************************
  // Request to the core
  // ****************************************
  logic [7:0] pflags;
  logic core_hit;
  logic periph_hit;
  logic irq_q;

  assign pflags = peripheral_flag_word & pie_impl;
  assign core_hit = (ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_IRQ_EN_BIT] & ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT])
                  | (ctrl_q[ciefc_pkg::EXTIE_BIT] & ctrl_q[ciefc_pkg::EXTF_BIT])
                  | (ctrl_q[ciefc_pkg::PCIE_BIT] & ctrl_q[ciefc_pkg::PCF_BIT]);
  // Each enable bit lines up with its flag bit
  assign periph_hit = ctrl_q[ciefc_pkg::PGATE_BIT] & (|(pie_q & pflags));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ctrl_q[ciefc_pkg::GIE_BIT] & (core_hit | periph_hit);
    end
  end

  assign core_irq_req = irq_q;

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rsp.rdata = 32'h0000_0000;
    rsp.err = 1'b0;
    if (sel_ctrl) begin
      rsp.rdata[7:0] = ctrl_q;
    end else if (sel_pie) begin
      rsp.rdata[7:0] = pie_q;
    end else if (sel_t0) begin
      rsp.rdata[7:0] = t0cnt_q;
    end else if (sel_stat) begin
      rsp.rdata[7:0] = pflags;
      rsp.rdata[8] = irq_q;
      rsp.rdata[14:9] = port_level;
      rsp.rdata[15] = ext_level;
    end else begin
      rsp.err = 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_clear_ext;
    wr_ctrl && !req.wdata[ciefc_pkg::EXTF_BIT] && !ext_evt;
  endsequence

  sequence s_t0_armed;
    ctrl_q[ciefc_pkg::GIE_BIT] && ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_IRQ_EN_BIT] && ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT];
  endsequence

  sequence s_periph_armed;
    ctrl_q[ciefc_pkg::GIE_BIT] && ctrl_q[ciefc_pkg::PGATE_BIT] && (|(pie_q & pflags));
  endsequence

  a_gie_blocks_req: assert property (!ctrl_q[ciefc_pkg::GIE_BIT] |=> !irq_q)
    else $error("request raised with global enable clear");

  a_gate_masks_periph: assert property (
    ctrl_q[ciefc_pkg::GIE_BIT] && !ctrl_q[ciefc_pkg::PGATE_BIT] && !core_hit |=> !irq_q)
    else $error("peripheral request passed a closed gate");

  a_t0_raises_req: assert property (s_t0_armed |=> irq_q)
    else $error("timer0 request missing");

  a_ext_raises_req: assert property (
    ctrl_q[ciefc_pkg::GIE_BIT] && ctrl_q[ciefc_pkg::EXTIE_BIT] && ctrl_q[ciefc_pkg::EXTF_BIT] |=> irq_q)
    else $error("external pin request missing");

  a_port_masked_pin: assert property (
    ((port_rise | port_fall) & ~port_change_mask) != 6'h00 && !port_evt && !wr_ctrl
    && !ctrl_q[ciefc_pkg::PCF_BIT] |=> !ctrl_q[ciefc_pkg::PCF_BIT])
    else $error("masked pin set the port-change flag");

  // Software may clear the flag at once, so the second cycle only holds without that write
  a_t0_flag_set: assert property (
    t0_ovf |=> ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT] ##1 (ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT] || $past(wr_ctrl)))
    else $error("timer0 flag not set and held after rollover");

  a_t0_flag_hold: assert property (
    ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT] && !wr_ctrl |=> ctrl_q[ciefc_pkg::TIMER0_OVERFLOW_FLAG_BIT])
    else $error("timer0 flag dropped without a write");

  a_t0_wrap_zero: assert property (t0_ovf |=> t0cnt_q == 8'h00)
    else $error("timer0 count did not wrap to zero");

  a_ext_sets_flag: assert property (ext_evt |=> ctrl_q[ciefc_pkg::EXTF_BIT])
    else $error("external edge did not set its flag");

  a_port_sets_flag: assert property (port_evt |=> ctrl_q[ciefc_pkg::PCF_BIT])
    else $error("port change did not set its flag");

  a_pie_write_lands: assert property (
    wr_pie |=> pie_q == ($past(req.wdata[7:0]) & pie_impl))
    else $error("peripheral enable write did not land");

  a_cmp_one_req: assert property (
    ctrl_q[ciefc_pkg::GIE_BIT] && ctrl_q[ciefc_pkg::PGATE_BIT] && pie_q[ciefc_pkg::CMP1_BIT]
    && pflags[ciefc_pkg::CMP1_BIT] |=> irq_q)
    else $error("comparator one request missing");

  a_t1_ovf_req: assert property (
    ctrl_q[ciefc_pkg::GIE_BIT] && ctrl_q[ciefc_pkg::PGATE_BIT] && pie_q[ciefc_pkg::T1_BIT]
    && pflags[ciefc_pkg::T1_BIT] |=> irq_q)
    else $error("timer1 overflow request missing");

  a_flag_no_enable: assert property (
    ext_evt && !ctrl_q[ciefc_pkg::EXTIE_BIT] && !ctrl_q[ciefc_pkg::GIE_BIT] |=> ctrl_q[ciefc_pkg::EXTF_BIT])
    else $error("flag depended on its enable");

  a_ext_flag_clear: assert property (s_clear_ext |=> !ctrl_q[ciefc_pkg::EXTF_BIT])
    else $error("external flag did not clear on write of zero");

  a_port_flag_hold: assert property (
    ctrl_q[ciefc_pkg::PCF_BIT] && !wr_ctrl |=> ctrl_q[ciefc_pkg::PCF_BIT])
    else $error("port-change flag dropped without a write");

  a_pie_unimpl: assert property (pie_q[7] == 1'b0 && pie_q[2] == 1'b0)
    else $error("unimplemented enable bit set");

  a_reduced_zero: assert property (
    !FULL_VARIANT |-> (pie_q & ~ciefc_pkg::PIE_IMPL_RED) == 8'h00)
    else $error("reduced variant holds an absent enable");

  a_periph_req: assert property (s_periph_armed |=> irq_q)
    else $error("peripheral request missing");

  a_t0_keep_reset: assert property (
    @(posedge core_clk) disable iff (1'b0) rst |=> $stable(t0cnt_q))
    else $error("timer0 count changed during reset");

endmodule

// >>> logic/ciefc_pkg.sv
package ciefc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PIE_OFF = 8'h04;
  localparam logic [7:0] T0CNT_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0C;

  // ****************************************
  // Core control bit positions
  // ****************************************
  localparam int GIE_BIT = 7;
  localparam int PGATE_BIT = 6;
  localparam int TIMER0_OVERFLOW_IRQ_EN_BIT = 5;
  localparam int EXTIE_BIT = 4;
  localparam int PCIE_BIT = 3;
  localparam int TIMER0_OVERFLOW_FLAG_BIT = 2;
  localparam int EXTF_BIT = 1;
  localparam int PCF_BIT = 0;
  localparam int NUM_CORE_SRC = 3;

  // ****************************************
  // Peripheral enable bit positions
  // ****************************************
  localparam int ADC_BIT = 6;
  localparam int CAPCOMP_BIT = 5;
  localparam int CMP2_BIT = 4;
  localparam int CMP1_BIT = 3;
  localparam int T2_BIT = 1;
  localparam int T1_BIT = 0;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PIE_RST = 8'h00;
  localparam logic [7:0] PIE_IMPL_FULL = 8'h7B;
  localparam logic [7:0] PIE_IMPL_RED = 8'h19;
  localparam logic [7:0] T0_MAX = 8'hFF;
  localparam int PORT_W = 6;
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // ****************************************
  // Register access carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } ciefc_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } ciefc_rsp_t;

endpackage

// >>> logic/ciefc_pin_sync.sv
`timescale 1ns/1ns
module ciefc_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Raw pins
  input wire logic [W-1:0] pins,
  // Synchronised view
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [1:0] fill_q;

  always_ff @(posedge core_clk) begin
    meta_q <= pins;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  // Edges stay masked until the chain holds real pin values
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fill_q <= 2'h0;
    end else if (fill_q != ciefc_pkg::SYNC_FILL) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  assign level = sync_q;
  assign rise = (fill_q == ciefc_pkg::SYNC_FILL) ? (sync_q & ~prev_q) : '0;
  assign fall = (fill_q == ciefc_pkg::SYNC_FILL) ? (~sync_q & prev_q) : '0;

endmodule

// >>> logic/ciefc_apb_port.sv
`timescale 1ns/1ns
module ciefc_apb_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Register side
  output ciefc_pkg::ciefc_req_t req,
  output logic wr_en,
  input wire ciefc_pkg::ciefc_rsp_t rsp
);

  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic first_access;

  // One wait state lets the read data come from a flop
  assign first_access = psel & penable & ~pready_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= first_access;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (first_access) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rsp.rdata;
      pslverr_q <= rsp.err;
    end
  end

  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

endmodule

// >>> sim/ciefc_src_model.sv
`timescale 1ns/1ns
module ciefc_src_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Event commands
  input wire logic [7:0] set_w,
  input wire logic [7:0] clr_w,
  // Flags seen by the controller
  output logic [7:0] peripheral_flag_word
);
  // ****************************************
  // Peripheral flag register
  // ****************************************
  // Flags latch whatever the enables say; only a clear drops them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      peripheral_flag_word <= 8'h00;
    end else begin
      peripheral_flag_word <= (peripheral_flag_word & ~clr_w) | set_w;
    end
  end
endmodule

// >>> sim/ciefc_ctrl_tb.sv
`timescale 1ns/1ns
module ciefc_ctrl_tb;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pie;
    logic [7:0] pflag;
    logic irq;
  } ciefc_row_t;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, tick, ext_pin, core_irq_req, ev, edge_up;
  logic [7:0] paddr, set_w, clr_w, pflags, rv, rv_r;
  logic [31:0] pwdata, prdata, prdata_r;
  logic [5:0] pins, mask;
  int num_errors = 0;
  int checked = 0;
  ciefc_row_t rows [10];

  ciefc_src_model i_ciefc_src_model (.core_clk(core_clk), .rst(rst), .set_w(set_w), .clr_w(clr_w),
    .peripheral_flag_word(pflags));
  ciefc_ctrl i_ciefc_ctrl (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .timer0_tick(tick),
    .ext_edge_pin(ext_pin), .ext_edge_rising(edge_up), .port_a_pins(pins), .port_change_mask(mask),
    .peripheral_flag_word(pflags), .core_irq_req(core_irq_req));
  // Reduced variant shares the bus; only its read data is watched
  ciefc_ctrl #(.FULL_VARIANT(1'b0)) i_ciefc_ctrl_red (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata_r),
    .pslverr(), .timer0_tick(tick), .ext_edge_pin(ext_pin), .ext_edge_rising(edge_up), .port_a_pins(pins),
    .port_change_mask(mask), .peripheral_flag_word(pflags), .core_irq_req());

  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict;
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
    end
  endtask

  // Holds the whole request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(8'h00, 8'h01);
    rv = prdata[7:0];
    rv_r = prdata_r[7:0];
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(rv, x);
  endtask

  // Request is registered: allow its one-edge lag before looking
  task automatic ic(input logic x);
    repeat (2) @(posedge core_clk);
    chk({7'h00, core_irq_req}, {7'h00, x});
  endtask

  task automatic fl(input logic [7:0] s, input logic [7:0] c);
    set_w <= s;
    clr_w <= c;
    @(posedge core_clk);
    set_w <= 8'h00;
    clr_w <= 8'h00;
    @(posedge core_clk);
  endtask

  task automatic pulse_tick;
    tick <= 1'b1;
    @(posedge core_clk);
    tick <= 1'b0;
    @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, tick, ext_pin} = 5'h00;
    edge_up = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {set_w, clr_w} = 16'h0000;
    pins = 6'h00;
    mask = 6'h3F;
    rows = '{'{8'hC0, 8'h40, 8'h40, 1'b1}, '{8'hC0, 8'h20, 8'h20, 1'b1}, '{8'hC0, 8'h18, 8'h10, 1'b1},
      '{8'hC0, 8'h08, 8'h10, 1'b0}, '{8'hC0, 8'h02, 8'h02, 1'b1}, '{8'hC0, 8'h01, 8'h01, 1'b1},
      '{8'h80, 8'h7B, 8'h7B, 1'b0}, '{8'h40, 8'h7B, 8'h7B, 1'b0}, '{8'hC0, 8'h84, 8'h84, 1'b0},
      '{8'hC0, 8'h00, 8'h7B, 1'b0}};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(ciefc_pkg::CTRL_OFF, 8'h00);
    rd(ciefc_pkg::PIE_OFF, 8'h00);
    foreach (rows[i]) begin
      fl(8'h00, 8'hFF);
      apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h00);
      apb(1'b1, ciefc_pkg::PIE_OFF, rows[i].pie);
      fl(rows[i].pflag, 8'h00);
      apb(1'b1, ciefc_pkg::CTRL_OFF, rows[i].ctrl);
      ic(rows[i].irq);
      rd(ciefc_pkg::PIE_OFF, rows[i].pie & ciefc_pkg::PIE_IMPL_FULL);
      chk(rv_r, rows[i].pie & ciefc_pkg::PIE_IMPL_RED);
      rd(ciefc_pkg::STAT_OFF, rows[i].pflag & ciefc_pkg::PIE_IMPL_FULL);
    end
    apb(1'b0, 8'h10, 8'h00);
    chk({rv[6:0], ev}, 8'h01);
    // Timer0 rollover with every enable off
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h00);
    apb(1'b1, ciefc_pkg::T0CNT_OFF, 8'hFF);
    pulse_tick();
    rd(ciefc_pkg::CTRL_OFF, 8'h04);
    rd(ciefc_pkg::T0CNT_OFF, 8'h00);
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'hA4);
    ic(1'b1);
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'hA0);
    ic(1'b0);
    // External edge, then port change with and without the pin mask
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h00);
    ext_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(ciefc_pkg::CTRL_OFF, 8'h02);
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h92);
    ic(1'b1);
    // Falling edge counts once the edge select is low
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h00);
    edge_up <= 1'b0;
    ext_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(ciefc_pkg::CTRL_OFF, 8'h02);
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h00);
    mask <= 6'h00;
    pins <= 6'h08;
    repeat (6) @(posedge core_clk);
    rd(ciefc_pkg::CTRL_OFF, 8'h00);
    mask <= 6'h3F;
    pins <= 6'h00;
    repeat (6) @(posedge core_clk);
    rd(ciefc_pkg::CTRL_OFF, 8'h01);
    apb(1'b1, ciefc_pkg::CTRL_OFF, 8'h89);
    ic(1'b1);
    // Count must survive a reset while the control register clears
    apb(1'b1, ciefc_pkg::T0CNT_OFF, 8'h5A);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(ciefc_pkg::T0CNT_OFF, 8'h5A);
    rd(ciefc_pkg::CTRL_OFF, 8'h00);
    give_verdict();
  end
endmodule
